// [serial_master.sv]
/*
 Bus master model: drives select, shift clock and data, reads the data line.
 Assumes core_clk runs 8x the shift clock; stimulus moves on its rising edge.
*/
module serial_master (
   input wire logic core_clk,
   input wire logic sio_out,
   input wire logic sio_oe,
   output logic serial_shift_clock,
   output logic cs_n,
   output logic sio_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic m_d = 1'b0;
   logic m_oe = 1'b0;
   logic last_r = 1'b0;
   int n_drv;
   initial begin
      cs_n = 1'b1;
      serial_shift_clock = 1'b0;
   end
   // A released line toggles so that a stale value never passes as data
   always_comb sio_in = sio_oe ? sio_out : (m_oe ? m_d : ~last_r);
   always @(posedge core_clk) last_r <= sio_in;
   // One frame: ntx + nrx clocks, the first 16 read and the rest written, MSB first
   task automatic frame(input logic [15:0] wr, input int ntx, input int nrx, output logic [15:0] rd);
      rd = 16'h0000;
      n_drv = 0;
      @(posedge core_clk) cs_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      for (int i = 0; i < ntx + nrx; i++) begin
         @(posedge core_clk) serial_shift_clock <= 1'b0;
         m_oe <= (i >= 16);
         m_d <= wr[(31 - i) % 16];
         repeat (3) @(posedge core_clk);
         @(posedge core_clk) serial_shift_clock <= 1'b1;
         @(negedge core_clk);
         if (i < 16) begin
            rd[15 - i] = sio_in;
            n_drv += int'(sio_oe);
         end
         repeat (3) @(posedge core_clk);
      end
      // Clock parks low before select rises, so it stands still between frames
      @(posedge core_clk) serial_shift_clock <= 1'b0;
      m_oe <= 1'b0;
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b1;
   endtask
endmodule

// [temp_serial_consts.svh]
/*
 Constants for the temperature sensor serial slave port.
 Assumes inclusion by the package and the design file; definitions only.
*/
`ifndef TEMP_SERIAL_CONSTS_SVH
`define TEMP_SERIAL_CONSTS_SVH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define PHASE_BITS 16
`define FRAME_BITS 32
`define DRIVEN_BITS 14
`define CMD_BITS 8
`define CNT_W 6
`define WORD_W 16
`define TEMP_W 11
`define TAIL_ONES 3'h7
`define SHUTDOWN_CODE 8'hFF
// Identity word, arbitrary neutral value; low two bits are never driven
`define ID_WORD_DEFAULT 16'hA5A4
`define TEMP_INVALID 11'h000
`endif

// [temp_serial_pkg.sv]
/*
 Types for the temperature sensor serial slave port.
 Assumes temp_serial_consts.svh is on the include path.
*/
package temp_serial_pkg;
`include "temp_serial_consts.svh"
   // Conversion mode selected by the last command byte
   typedef enum logic {mode_convert, mode_shutdown} conv_mode_t;
endpackage

// [temp_serial_port.sv]
/*
 Serial slave port of a digital temperature sensor: 16-bit transmit phase
 of temperature or identity, 16-bit receive phase of a mode command.
 Assumes serial_shift_clock and chip select come from an off-chip master and
 are sampled by core_clk (25 MHz) which runs at least 8x the shift clock.
 The converter supplies temp_in with a one-cycle conv_done pulse.
 Limitation: a mode command takes effect only when select rises, so the
 identity word is read in the frame after the shutdown command.
 Inputs from the master are never used before they pass two flops.
*/
`include "temp_serial_consts.svh"

module temp_serial_port
   import temp_serial_pkg::*;
#(
   parameter logic [`WORD_W-1:0] ID_WORD = `ID_WORD_DEFAULT
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic serial_shift_clock,
   input wire logic cs_n,
   input wire logic sio_in,
   output logic sio_out,
   output logic sio_oe,
   input wire logic [`TEMP_W-1:0] temp_in,
   input wire logic conv_done,
   output logic shutdown,
   output logic conv_busy_hold
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [1:0] sck_sync_r, sck_sync_nxt;
   logic [1:0] cs_sync_r, cs_sync_nxt;
   logic [1:0] din_sync_r, din_sync_nxt;
   logic sck_prev_r, sck_prev_nxt;
   logic cs_prev_r, cs_prev_nxt;
   logic sck_rise, sck_fall, cs_fall, cs_rise, cs_low;

   // Two flops each; only the second stage feeds edge logic
   always_comb begin
      sck_sync_nxt = {sck_sync_r[0], serial_shift_clock};
      cs_sync_nxt = {cs_sync_r[0], cs_n};
      din_sync_nxt = {din_sync_r[0], sio_in};
      sck_prev_nxt = sck_sync_r[1];
      cs_prev_nxt = cs_sync_r[1];
   end

   // Reset levels match the idle pins, select high and clock low,
   // so no false edge is seen on the first cycles after reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sck_sync_r <= 2'h0;
         cs_sync_r <= 2'h3;
         din_sync_r <= 2'h0;
         sck_prev_r <= 1'h0;
         cs_prev_r <= 1'h1;
      end else begin
         sck_sync_r <= sck_sync_nxt;
         cs_sync_r <= cs_sync_nxt;
         din_sync_r <= din_sync_nxt;
         sck_prev_r <= sck_prev_nxt;
         cs_prev_r <= cs_prev_nxt;
      end
   end

   // Edge detection on synchronised levels
   assign cs_low = !cs_sync_r[1];
   assign sck_rise = cs_low && sck_sync_r[1] && !sck_prev_r;
   assign sck_fall = cs_low && !sck_sync_r[1] && sck_prev_r;
   assign cs_fall = !cs_sync_r[1] && cs_prev_r;
   assign cs_rise = cs_sync_r[1] && !cs_prev_r;

   // ----------------------------------------
   // Conversion result holding
   // ----------------------------------------
   logic [`TEMP_W-1:0] temp_r, temp_nxt;
   logic [`TEMP_W-1:0] pend_r, pend_nxt;
   logic pend_valid_r, pend_valid_nxt;

   // A result finishing mid-frame waits until select rises, so the
   // word in flight is never torn; the converter itself is not held.
   always_comb begin
      temp_nxt = temp_r;
      pend_nxt = pend_r;
      pend_valid_nxt = pend_valid_r;
      if (conv_done && !cs_low) begin
         temp_nxt = temp_in;
         pend_valid_nxt = 1'b0;
      end else if (conv_done) begin
         pend_nxt = temp_in;
         pend_valid_nxt = 1'b1;
      end else if (!cs_low && pend_valid_r) begin
         temp_nxt = pend_r;
         pend_valid_nxt = 1'b0;
      end
   end

   // Result registers start at the invalid code until the first conversion
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         temp_r <= `TEMP_INVALID;
         pend_r <= `TEMP_INVALID;
         pend_valid_r <= 1'b0;
      end else begin
         temp_r <= temp_nxt;
         pend_r <= pend_nxt;
         pend_valid_r <= pend_valid_nxt;
      end
   end

   // Busy flag shows a finished result parked until the frame ends
   assign conv_busy_hold = pend_valid_r;

   // ----------------------------------------
   // Frame shifter and mode
   // ----------------------------------------
   conv_mode_t mode_r, mode_nxt;
   logic [`CNT_W-1:0] cnt_r, cnt_nxt;
   logic [`WORD_W-1:0] tx_r, tx_nxt;
   logic [`CMD_BITS-1:0] rx_r, rx_nxt;
   logic rx_seen_r, rx_seen_nxt;
   logic sio_out_r, sio_out_nxt;
   logic sio_oe_r, sio_oe_nxt;
   logic [`WORD_W-1:0] load_word;

   // Word chosen at select fall; identity replaces temperature in shutdown
   always_comb begin
      if (mode_r == mode_shutdown)
         load_word = ID_WORD;
      else
         load_word = {temp_r, `TAIL_ONES, 2'h0};
   end

   always_comb begin
      mode_nxt = mode_r;
      cnt_nxt = cnt_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      rx_seen_nxt = rx_seen_r;
      sio_out_nxt = sio_out_r;
      sio_oe_nxt = sio_oe_r;
      // Select high: line released, command applied on the rising select
      if (!cs_low) begin
         sio_oe_nxt = 1'b0;
         cnt_nxt = '0;
         rx_seen_nxt = 1'b0;
         if (cs_rise && rx_seen_r)
            mode_nxt = (rx_r == `SHUTDOWN_CODE) ? mode_shutdown : mode_convert;
      end else if (cs_fall) begin
         tx_nxt = load_word;
         sio_out_nxt = load_word[`WORD_W-1];
         sio_oe_nxt = 1'b1;
         cnt_nxt = '0;
      end else begin
         // Rising edges past the transmit phase sample the line; count stops at the frame end
         if (sck_rise) begin
            if (cnt_r >= `CNT_W'(`PHASE_BITS)) begin
               rx_nxt = {rx_r[`CMD_BITS-2:0], din_sync_r[1]};
               rx_seen_nxt = 1'b1;
            end
            if (cnt_r < `CNT_W'(`FRAME_BITS))
               cnt_nxt = cnt_r + `CNT_W'(1);
         end
         // Falling edges of the transmit phase move the next bit out
         if (sck_fall && cnt_r < `CNT_W'(`PHASE_BITS)) begin
            tx_nxt = {tx_r[`WORD_W-2:0], 1'b0};
            sio_out_nxt = tx_r[`WORD_W-2];
            sio_oe_nxt = (cnt_r < `CNT_W'(`DRIVEN_BITS));
         end
      end
   end

   // Mode resets to conversion so readings start with no command
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= mode_convert;
         cnt_r <= '0;
         tx_r <= '0;
         rx_r <= '0;
         rx_seen_r <= 1'b0;
         sio_out_r <= 1'b0;
         sio_oe_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         cnt_r <= cnt_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         rx_seen_r <= rx_seen_nxt;
         sio_out_r <= sio_out_nxt;
         sio_oe_r <= sio_oe_nxt;
      end
   end

   // Pins come straight from flops; no logic after the registers
   assign sio_out = sio_out_r;
   assign sio_oe = sio_oe_r;
   assign shutdown = (mode_r == mode_shutdown);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   release_cs_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_rise |=> !sio_oe) else $error("data line driven after select high");

   drive_cs_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_fall |=> sio_oe && sio_out == $past(load_word[`WORD_W-1])) else $error("first bit not driven");

   // The last driven bit still stands after the fourteenth rise, until the next fall
   release_14_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_low && !cs_fall && cnt_r > `CNT_W'(`DRIVEN_BITS) && !sck_fall |=> !sio_oe)
      else $error("line driven past fourteen bits");

   change_on_fall_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_low && !cs_fall && !sck_fall |=> $stable(sio_out)) else $error("output changed off falling edge");

   shutdown_cmd_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_rise && rx_seen_r && rx_r == `SHUTDOWN_CODE |=> shutdown) else $error("shutdown not entered");

   convert_cmd_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_rise && rx_seen_r && rx_r != `SHUTDOWN_CODE |=> !shutdown) else $error("conversion not resumed");

   mode_frame_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !cs_rise |=> $stable(mode_r)) else $error("mode changed without select rise");

   hold_result_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_low && !cs_rise |=> $stable(temp_r)) else $error("result changed during frame");

   load_after_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !cs_low && pend_valid_r && !conv_done |=> temp_r == $past(pend_r)) else $error("pending result lost");

   // ----------------------------------------
   // Assertions: shifter and converter hand-over
   // ----------------------------------------
   // Select high must keep the line released on every cycle, not only at the edge
   oe_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !cs_low |=> !sio_oe)
      else $error("data line driven while select high");

   // The loaded word decides what the master sees; both sources are checked
   id_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_fall && mode_r == mode_shutdown |=> tx_r == ID_WORD)
      else $error("identity word not loaded in shutdown");

   temp_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_fall && mode_r == mode_convert |=> tx_r == {$past(temp_r), `TAIL_ONES, 2'h0})
      else $error("temperature word not loaded");

   shift_next_a: assert property (@(posedge core_clk) disable iff (!nrst)
      sck_fall && !cs_fall && cnt_r < `CNT_W'(`PHASE_BITS) |=> sio_out == $past(tx_r[`WORD_W-2]))
      else $error("next bit not shifted out");

   // Each counted rising edge advances the count by exactly one
   count_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
      sck_rise && !cs_fall && cnt_r < `CNT_W'(`FRAME_BITS) |=> cnt_r == $past(cnt_r) + `CNT_W'(1))
      else $error("rising edge not counted");

   // Receive bits enter at the bottom, oldest falls off the top
   rx_shift_a: assert property (@(posedge core_clk) disable iff (!nrst)
      sck_rise && !cs_fall && cnt_r >= `CNT_W'(`PHASE_BITS)
      |=> rx_r == {$past(rx_r[`CMD_BITS-2:0]), $past(din_sync_r[1])})
      else $error("receive bit not shifted in");

   rx_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
      sck_rise && !cs_fall && cnt_r < `CNT_W'(`PHASE_BITS) |=> $stable(rx_r))
      else $error("receive register moved in transmit phase");

   // A frame cut before the receive phase must not touch the mode
   mode_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_rise && !rx_seen_r |=> $stable(mode_r))
      else $error("mode changed without receive bits");

   frame_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_rise |=> cnt_r == '0 && !rx_seen_r)
      else $error("frame state not cleared at select high");

   // Results arriving mid-frame are parked, idle ones go straight in
   busy_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cs_low && conv_done |=> conv_busy_hold)
      else $error("mid-frame result not parked");

   idle_update_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !cs_low && conv_done |=> temp_r == $past(temp_in) && !conv_busy_hold)
      else $error("idle result not taken");

endmodule

// [temp_serial_port_test.sv]
/*
 Self-checking bench for the sensor serial port, with a master model.
 Assumes the package and constants header compile first.
*/
`include "temp_serial_consts.svh"
module temp_serial_port_test
   import temp_serial_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Identity word, arbitrary value
   localparam logic [15:0] ID = 16'h5A38;
   logic core_clk, nrst, sck, cs_n, sio_in, sio_out, sio_oe, conv_done, shutdown, conv_busy_hold;
   logic [10:0] temp_in, t;
   logic sd;
   logic [7:0] r;
   int tests_run, n_fail, cyc;
   logic [7:0] codes[10] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'hFF, 8'hFF};
   temp_serial_port #(.ID_WORD(ID)) temp_serial_port_i (.core_clk(core_clk), .nrst(nrst),
      .serial_shift_clock(sck), .cs_n(cs_n), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
      .temp_in(temp_in), .conv_done(conv_done), .shutdown(shutdown), .conv_busy_hold(conv_busy_hold));
   serial_master serial_master_i (.core_clk(core_clk), .sio_out(sio_out), .sio_oe(sio_oe),
      .serial_shift_clock(sck), .cs_n(cs_n), .sio_in(sio_in));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Mode from the last eight bits of the first nrx sent
   function automatic logic exp_sd(input logic [15:0] wr, input int nrx);
      return ((wr >> (16 - nrx)) & 16'h00FF) == 16'h00FF;
   endfunction
   function automatic logic [15:0] exp_tx(input logic s, input logic [10:0] v);
      return s ? {ID[15:2], 2'b00} : {v, 3'h7, 2'b00};
   endfunction
   task automatic xfer(input logic [15:0] wr, input int ntx, input int nrx);
      logic [15:0] rd, ex;
      ex = exp_tx(sd, t);
      serial_master_i.frame(wr, ntx, nrx, rd);
      if (ntx == 16) check(rd & 16'hFFFC, ex);
      check(16'(serial_master_i.n_drv), 16'(ntx < 14 ? ntx : 14));
      if (nrx > 0) sd = exp_sd(wr, nrx);
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      check({14'h0, sio_oe, conv_busy_hold}, 16'h0000);
      check({15'h0, shutdown}, {15'h0, sd});
   endtask
   task automatic conv(input logic [10:0] v);
      @(posedge core_clk) temp_in <= v;
      conv_done <= 1'b1;
      @(posedge core_clk) conv_done <= 1'b0;
   endtask
   // Hang guard, well above the length of all tests
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      nrst = 1'b0;
      temp_in = 11'h000;
      conv_done = 1'b0;
      sd = 1'b0;
      t = 11'h000;
      r = 8'h00;
      void'($urandom(62577));
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check({15'h0, shutdown}, 16'h0000);
      xfer(16'h0000, 16, 0);
      $display("power-up read done");
      for (int k = 0; k < 6; k++) begin
         t = (k < 2) ? (k ? 11'h3FF : 11'h400) : 11'($urandom);
         conv(t);
         xfer(16'h0000, 16, 0);
      end
      $display("temperature reads done");
      fork
         xfer(16'h0000, 16, 0);
         begin
            repeat (60) @(posedge core_clk);
            conv(11'h155);
            @(negedge core_clk);
            check({15'h0, conv_busy_hold}, 16'h0001);
         end
      join
      t = 11'h155;
      xfer(16'hFFFF, 5, 0);
      xfer(16'h0000, 16, 0);
      $display("conversion during frame done");
      for (int k = 0; k < 10; k++) begin
         r = 8'($urandom);
         if (k % 2) xfer({codes[k], r}, 16, 8);
         else xfer({r, codes[k]}, 16, 16);
      end
      xfer(16'h0000, 16, 0);
      xfer(16'h0000, 16, 8);
      t = 11'($urandom);
      conv(t);
      xfer(16'h00FF, 16, 16);
      xfer(16'h0000, 16, 0);
      $display("command codes done");
      @(posedge core_clk) nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      sd = 1'b0;
      t = 11'h000;
      repeat (3) @(posedge core_clk);
      xfer(16'h0000, 16, 0);
      $display("mid-run reset done");
      print_verdict();
   end
endmodule
